// ### src/pod_adapter_pkg.sv
// Package with host addresses, mode bit positions and reset values of the pod adapter.
package pod_adapter_pkg;
   // ************************************************************
   // Host address map.
   // ************************************************************
   localparam logic [15:0] ADDR_MODE = 16'h2002;
   localparam logic [15:0] ADDR_P0_LOW = 16'h2004;
   localparam logic [15:0] ADDR_P0_HIGH = 16'h2005;
   localparam logic [15:0] ADDR_P3_LOW = 16'h2006;
   localparam logic [15:0] ADDR_P3_HIGH = 16'h2007;

   // ************************************************************
   // Mode register fields and reset value.
   // ************************************************************
   localparam int MODE_READBACK = 4;
   localparam int MODE_DUAL_USE = 5;
   localparam int MODE_STROBE_EN = 6;
   localparam int MODE_RW_EN = 7;
   localparam logic [7:0] MODE_RESET = 8'h00_C0;

   // ************************************************************
   // Layout of the control line readback byte.
   // ************************************************************
   localparam int CTRL_SENSE_STROBE = 0;
   localparam int CTRL_SENSE_RW = 1;

   // Nibble geometry.
   localparam int NIBBLE = 4;
   localparam logic [3:0] NIBBLE_ALL = 4'h0_F;
   localparam logic [3:0] NIBBLE_NONE = 4'h0_0;
endpackage

// ### src/nibble_port.sv
// One bidirectional port nibble with direction latch and readback path.
`timescale 1ns/10ps
module nibble_port (
   input wire logic i_clock, // System clock.
   input wire logic i_rst_b, // Asynchronous reset, active low.
   input wire logic i_rd, // Host read of this nibble.
   input wire logic i_wr, // Host write of this nibble.
   input wire logic i_readback, // Readback select mode bit.
   input wire logic [3:0] i_wdata, // Host write data.
   input wire logic [3:0] i_pin, // Levels seen by the port input path.
   input wire logic [3:0] i_sense, // Levels seen by the sensing expander.
   output logic [3:0] o_out, // Latched output data.
   output logic [3:0] o_oe, // Output enable, high while driving.
   output logic [3:0] o_rdata // Read data for the host.
);
   logic out_dir;
   logic [3:0] latch;

   // A normal read turns the nibble to input, a normal write turns it to output; readback keeps it.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_dir <= 1'b0;
      end else if (!i_readback && i_wr) begin
         out_dir <= 1'b1;
      end else if (!i_readback && i_rd) begin
         out_dir <= 1'b0;
      end
   end

   // Writes are latched only with readback off, so the driven value survives readback.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         latch <= pod_adapter_pkg::NIBBLE_NONE;
      end else if (!i_readback && i_wr) begin
         latch <= i_wdata;
      end
   end

   assign o_out = latch;
   assign o_oe = out_dir ? pod_adapter_pkg::NIBBLE_ALL : pod_adapter_pkg::NIBBLE_NONE;

   // Readback returns the sensed levels, otherwise the port levels.
   assign o_rdata = i_readback ? i_sense : i_pin;
endmodule

// ### src/pod_adapter_mode_readback.sv
// Mode register, rebuilt ports 0 and 3 and drivability readback of the pod adapter.
`timescale 1ns/10ps
// Functional notes
// - The mode register is written and read by the host at address 2002.
// - With the readback bit clear, accesses at 2004 to 2007 are plain input and output on ports 0 and 3.
// - With the readback bit set, last written outputs stay driven and reads return the sensed pin levels.
// - A read of 2006 with readback set returns the sensed data strobe and read/write levels.
// - Host bus port and first I/O port go straight to target ports 1 and 2, with crystal and reset passed.
// - Ports 0 and 3 come from the expander logic, three control lines from host strobes, and a sense path reads levels.
// - Port 0 line numbers equal bit positions, low nibble lines 0-3 and high nibble lines 4-7; port 3 lines 4-7 are bits 0-3.
// - Mode bit 6 low forces the data strobe low and mode bit 7 low forces the read/write line low.
// - Mode bit 5 low makes line 4 of port 3 a latched output, high makes it the data memory select.
// - A normal read of 2004 or 2005 makes that nibble an input, a write makes it an output and latches data.
module pod_adapter_mode_readback (
   input wire logic i_clock, // System clock, 100 MHz.
   input wire logic i_rst_b, // Asynchronous reset, active low.
   input wire logic [15:0] i_host_addr, // Host cycle address.
   input wire logic i_host_rd, // Host read strobe, one cycle.
   input wire logic i_host_wr, // Host write strobe, one cycle.
   input wire logic [7:0] i_host_wdata, // Host write data.
   output logic [7:0] o_host_rdata, // Host read data, registered.
   output logic o_host_rd_valid, // Read data valid pulse.
   input wire logic i_host_ds_low, // Host data strobe, active low.
   input wire logic i_host_rw_low, // Host read/write control.
   input wire logic i_host_dm_low, // Host data memory select, active low.
   output logic o_data_strobe_low, // Target data strobe, active low.
   output logic o_rw_low, // Target read/write line.
   output logic o_data_memory_select_low, // Unused copy of the data memory select.
   input wire logic [7:0] i_port0_in, // Port 0 pin levels.
   output logic [7:0] o_port0_out, // Port 0 output data.
   output logic [7:0] o_port0_oe, // Port 0 output enables.
   input wire logic [3:0] i_input_only_nibble_lines, // Port 3 lines 0-3.
   output logic [3:0] o_output_only_nibble_lines, // Port 3 lines 4-7, line 4 dual use.
   input wire logic [7:0] i_sense_port0, // Sensed port 0 levels.
   input wire logic [3:0] i_sense_port3_high, // Sensed port 3 lines 4-7.
   input wire logic i_sense_strobe_low, // Sensed data strobe level.
   input wire logic i_sense_rw_low, // Sensed read/write level.
   input wire logic [7:0] i_host_bus_out, // Host bus port output data.
   input wire logic [7:0] i_host_bus_oe, // Host bus port output enables.
   output logic [7:0] o_host_bus_in, // Levels back to the host bus port.
   output logic [7:0] o_target_p1_out, // Target port 1 output data.
   output logic [7:0] o_target_p1_oe, // Target port 1 output enables.
   input wire logic [7:0] i_target_p1_in, // Target port 1 levels.
   input wire logic [7:0] i_host_io1_out, // Host first I/O port data.
   input wire logic [7:0] i_host_io1_oe, // Host first I/O port enables.
   output logic [7:0] o_host_io1_in, // Levels back to host I/O port.
   output logic [7:0] o_target_p2_out, // Target port 2 output data.
   output logic [7:0] o_target_p2_oe, // Target port 2 output enables.
   input wire logic [7:0] i_target_p2_in, // Target port 2 levels.
   input wire logic i_host_reset_low, // Host reset, active low.
   output logic o_target_reset_low, // Target reset, active low.
   input wire logic i_host_xtal, // Host crystal drive.
   output logic o_target_xtal // Target crystal line.
);
   logic [7:0] mode;
   logic [3:0] p3_latch;
   logic [7:0] next_rdata;
   logic [7:0] nib_rdata;
   logic readback;

   // Address compare used by every decode.
   function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
      hit = (addr == target);
   endfunction

   // ************************************************************
   // Mode register.
   // ************************************************************

   // The mode register holds the last host write at its address.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode <= pod_adapter_pkg::MODE_RESET;
      end else if (i_host_wr && hit(i_host_addr, pod_adapter_pkg::ADDR_MODE)) begin
         mode <= i_host_wdata;
      end
   end

   assign readback = mode[pod_adapter_pkg::MODE_READBACK];

   // ************************************************************
   // Port 0 nibbles.
   // ************************************************************

   // Each nibble of port 0 has its own direction and latch, lines numbered by bit.
   for (genvar n = 0; n < 2; n++) begin : g_p0
      nibble_port u_nib (
         .i_clock(i_clock),
         .i_rst_b(i_rst_b),
         .i_rd(i_host_rd && hit(i_host_addr, pod_adapter_pkg::ADDR_P0_LOW + 16'(n))),
         .i_wr(i_host_wr && hit(i_host_addr, pod_adapter_pkg::ADDR_P0_LOW + 16'(n))),
         .i_readback(readback),
         .i_wdata(i_host_wdata[3:0]),
         .i_pin(i_port0_in[n*pod_adapter_pkg::NIBBLE +: pod_adapter_pkg::NIBBLE]),
         .i_sense(i_sense_port0[n*pod_adapter_pkg::NIBBLE +: pod_adapter_pkg::NIBBLE]),
         .o_out(o_port0_out[n*pod_adapter_pkg::NIBBLE +: pod_adapter_pkg::NIBBLE]),
         .o_oe(o_port0_oe[n*pod_adapter_pkg::NIBBLE +: pod_adapter_pkg::NIBBLE]),
         .o_rdata(nib_rdata[n*pod_adapter_pkg::NIBBLE +: pod_adapter_pkg::NIBBLE])
      );
   end

   // ************************************************************
   // Port 3 and control lines.
   // ************************************************************

   // Lines 4-7 of port 3 latch on normal writes only; writes at the input-only address do nothing.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         p3_latch <= pod_adapter_pkg::NIBBLE_NONE;
      end else if (i_host_wr && !readback && hit(i_host_addr, pod_adapter_pkg::ADDR_P3_HIGH)) begin
         p3_latch <= i_host_wdata[3:0];
      end
   end

   // Line 4 is either the latched output or the data memory select.
   always_comb begin
      o_output_only_nibble_lines = p3_latch;
      if (mode[pod_adapter_pkg::MODE_DUAL_USE]) begin
         o_output_only_nibble_lines[0] = i_host_dm_low;
      end
   end

   // Control lines follow the host strobes unless forced low by their mode bits.
   assign o_data_strobe_low = mode[pod_adapter_pkg::MODE_STROBE_EN] & i_host_ds_low;
   assign o_rw_low = mode[pod_adapter_pkg::MODE_RW_EN] & i_host_rw_low;
   assign o_data_memory_select_low = i_host_dm_low;

   // ************************************************************
   // Pass-through ports.
   // ************************************************************

   // Ports 1 and 2, reset and crystal connect straight through with no logic.
   assign o_target_p1_out = i_host_bus_out;
   assign o_target_p1_oe = i_host_bus_oe;
   assign o_host_bus_in = i_target_p1_in;
   assign o_target_p2_out = i_host_io1_out;
   assign o_target_p2_oe = i_host_io1_oe;
   assign o_host_io1_in = i_target_p2_in;
   assign o_target_reset_low = i_host_reset_low;
   assign o_target_xtal = i_host_xtal;

   // ************************************************************
   // Host read path.
   // ************************************************************

   // Read data selection; readback swaps pin levels and the port 3 latch for sensed levels.
   always_comb begin
      next_rdata = 8'h00_00;
      if (hit(i_host_addr, pod_adapter_pkg::ADDR_MODE)) begin
         next_rdata = mode;
      end else if (hit(i_host_addr, pod_adapter_pkg::ADDR_P0_LOW)) begin
         next_rdata[3:0] = nib_rdata[3:0];
      end else if (hit(i_host_addr, pod_adapter_pkg::ADDR_P0_HIGH)) begin
         next_rdata[3:0] = nib_rdata[7:4];
      end else if (hit(i_host_addr, pod_adapter_pkg::ADDR_P3_LOW)) begin
         if (readback) begin
            next_rdata[pod_adapter_pkg::CTRL_SENSE_STROBE] = i_sense_strobe_low;
            next_rdata[pod_adapter_pkg::CTRL_SENSE_RW] = i_sense_rw_low;
         end else begin
            next_rdata[3:0] = i_input_only_nibble_lines;
         end
      end else if (hit(i_host_addr, pod_adapter_pkg::ADDR_P3_HIGH)) begin
         next_rdata[3:0] = readback ? i_sense_port3_high : p3_latch;
      end
   end

   // Read data is registered one cycle after the read strobe.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_host_rdata <= 8'h00_00;
         o_host_rd_valid <= 1'b0;
      end else begin
         o_host_rd_valid <= i_host_rd;
         if (i_host_rd) begin
            o_host_rdata <= next_rdata;
         end
      end
   end

   // ************************************************************
   // Assertions.
   // ************************************************************

   sequence s_mode_write;
      i_host_wr && i_host_addr == pod_adapter_pkg::ADDR_MODE;
   endsequence

   sequence s_read_at(logic [15:0] a);
      i_host_rd && i_host_addr == a;
   endsequence

   property p_mode_written;
      @(posedge i_clock) disable iff (!i_rst_b) s_mode_write |=> mode == $past(i_host_wdata);
   endproperty
   a_mode_written: assert property (p_mode_written) else $error("Mode write not stored.");

   property p_mode_readback;
      @(posedge i_clock) disable iff (!i_rst_b)
         s_mode_write ##1 !i_host_wr ##1 s_read_at(pod_adapter_pkg::ADDR_MODE)
         |=> o_host_rdata == $past(i_host_wdata, 3);
   endproperty
   a_mode_readback: assert property (p_mode_readback) else $error("Mode read differs from write.");

   property p_p0_normal_read;
      @(posedge i_clock) disable iff (!i_rst_b)
         s_read_at(pod_adapter_pkg::ADDR_P0_LOW) ##0 !readback
         |=> o_host_rd_valid && o_host_rdata[3:0] == $past(i_port0_in[3:0]) && o_port0_oe[3:0] == 4'h0_0;
   endproperty
   a_p0_normal_read: assert property (p_p0_normal_read) else $error("Port 0 low read wrong.");

   property p_p0_write_drives;
      @(posedge i_clock) disable iff (!i_rst_b)
         i_host_wr && i_host_addr == pod_adapter_pkg::ADDR_P0_HIGH && !readback
         |=> o_port0_oe[7:4] == 4'h0_F && o_port0_out[7:4] == $past(i_host_wdata[3:0]);
   endproperty
   a_p0_write_drives: assert property (p_p0_write_drives) else $error("Port 0 high write not driven.");

   property p_readback_holds;
      @(posedge i_clock) disable iff (!i_rst_b)
         readback && $stable(mode) ##1 readback |-> $stable(o_port0_out) && $stable(p3_latch);
   endproperty
   a_readback_holds: assert property (p_readback_holds) else $error("Outputs changed in readback.");

   property p_readback_sense;
      @(posedge i_clock) disable iff (!i_rst_b)
         s_read_at(pod_adapter_pkg::ADDR_P3_HIGH) ##0 readback |=> o_host_rdata[3:0] == $past(i_sense_port3_high);
   endproperty
   a_readback_sense: assert property (p_readback_sense) else $error("Port 3 readback wrong.");

   property p_ctrl_sense;
      @(posedge i_clock) disable iff (!i_rst_b)
         s_read_at(pod_adapter_pkg::ADDR_P3_LOW) ##0 readback
         |=> o_host_rdata[1:0] == {$past(i_sense_rw_low), $past(i_sense_strobe_low)};
   endproperty
   a_ctrl_sense: assert property (p_ctrl_sense) else $error("Control readback wrong.");

   property p_force_low;
      @(posedge i_clock) disable iff (!i_rst_b)
         !mode[pod_adapter_pkg::MODE_STROBE_EN] |-> !o_data_strobe_low;
   endproperty
   a_force_low: assert property (p_force_low) else $error("Data strobe not forced low.");

   property p_dual_use;
      @(posedge i_clock) disable iff (!i_rst_b)
         mode[pod_adapter_pkg::MODE_DUAL_USE] |-> o_output_only_nibble_lines[0] == i_host_dm_low;
   endproperty
   a_dual_use: assert property (p_dual_use) else $error("Line 4 not the memory select.");

   property p_pass_p1;
      @(posedge i_clock) disable iff (!i_rst_b)
         o_target_p1_out == i_host_bus_out && o_host_io1_in == i_target_p2_in;
   endproperty
   a_pass_p1: assert property (p_pass_p1) else $error("Pass-through broken.");
endmodule

// ### bench/uut_pin_model.sv
// Pin-level model of the unit under test that faces the rebuilt and passed ports.
`timescale 1ns/10ps
module uut_pin_model (
   input wire logic [7:0] i_p0_out, // Port 0 data from the adapter.
   input wire logic [7:0] i_p0_oe, // Port 0 enables from the adapter.
   input wire logic [3:0] i_p3_out, // Port 3 lines 4-7 from the adapter.
   input wire logic i_ds_low, // Data strobe from the adapter.
   input wire logic i_rw_low, // Read/write line from the adapter.
   input wire logic [7:0] i_p1_out, // Port 1 data from the adapter.
   input wire logic [7:0] i_p1_oe, // Port 1 enables from the adapter.
   input wire logic [7:0] i_p2_out, // Port 2 data from the adapter.
   input wire logic [7:0] i_p2_oe, // Port 2 enables from the adapter.
   input wire logic [7:0] i_stuck, // Port 0 lines held low by a board fault.
   input wire logic [7:0] i_ext, // Levels the target drives on released lines.
   output logic [7:0] o_p0_level, // Port 0 line levels.
   output logic [3:0] o_p3_level, // Port 3 lines 4-7 levels.
   output logic [3:0] o_p3_in, // Port 3 lines 0-3 driven by the target.
   output logic o_ds_level, // Data strobe line level.
   output logic o_rw_level, // Read/write line level.
   output logic [7:0] o_p1_level, // Port 1 line levels.
   output logic [7:0] o_p2_level // Port 2 line levels.
);
   // A released line carries what the target drives, and a faulty line stays low even when driven high.
   assign o_p0_level = ~i_stuck & ((i_p0_oe & i_p0_out) | (~i_p0_oe & i_ext));
   assign o_p3_level = i_p3_out;
   assign o_p3_in = i_ext[3:0];
   assign o_ds_level = i_ds_low;
   assign o_rw_level = i_rw_low;
   // The passed ports resolve the same way with no faulty lines, so the pod sees the real line levels.
   assign o_p1_level = (i_p1_oe & i_p1_out) | (~i_p1_oe & i_ext);
   assign o_p2_level = (i_p2_oe & i_p2_out) | (~i_p2_oe & i_ext);
endmodule

// ### bench/tb.sv
// Self-checking bench for the mode register and readback logic of the pod adapter.
`timescale 1ns/10ps
module tb;
   logic i_clock, i_rst_b, i_host_rd, i_host_wr, i_host_ds_low, i_host_rw_low, i_host_dm_low;
   logic i_host_reset_low, i_host_xtal, o_host_rd_valid, o_data_strobe_low, o_rw_low, o_data_memory_select_low;
   logic o_target_reset_low, o_target_xtal, i_sense_strobe_low, i_sense_rw_low;
   logic [15:0] i_host_addr;
   logic [7:0] i_host_wdata, o_host_rdata, i_port0_in, o_port0_out, o_port0_oe, i_sense_port0;
   logic [7:0] i_host_bus_out, i_host_bus_oe, o_host_bus_in, o_target_p1_out, o_target_p1_oe, i_target_p1_in;
   logic [7:0] i_host_io1_out, i_host_io1_oe, o_host_io1_in, o_target_p2_out, o_target_p2_oe, i_target_p2_in;
   logic [3:0] i_input_only_nibble_lines, o_output_only_nibble_lines, i_sense_port3_high;
   logic [7:0] stuck, ext, k;
   int err_total, compares;

   // ************************************************************
   // Design, target model and clock.
   // ************************************************************
   pod_adapter_mode_readback u_pod_adapter_mode_readback (.i_clock, .i_rst_b, .i_host_addr, .i_host_rd,
      .i_host_wr, .i_host_wdata, .o_host_rdata, .o_host_rd_valid, .i_host_ds_low, .i_host_rw_low,
      .i_host_dm_low, .o_data_strobe_low, .o_rw_low, .o_data_memory_select_low, .i_port0_in, .o_port0_out,
      .o_port0_oe, .i_input_only_nibble_lines, .o_output_only_nibble_lines, .i_sense_port0,
      .i_sense_port3_high, .i_sense_strobe_low, .i_sense_rw_low, .i_host_bus_out, .i_host_bus_oe,
      .o_host_bus_in, .o_target_p1_out, .o_target_p1_oe, .i_target_p1_in, .i_host_io1_out, .i_host_io1_oe,
      .o_host_io1_in, .o_target_p2_out, .o_target_p2_oe, .i_target_p2_in, .i_host_reset_low,
      .o_target_reset_low, .i_host_xtal, .o_target_xtal);
   uut_pin_model u_uut_pin_model (.i_p0_out(o_port0_out), .i_p0_oe(o_port0_oe),
      .i_p3_out(o_output_only_nibble_lines), .i_ds_low(o_data_strobe_low), .i_rw_low(o_rw_low),
      .i_p1_out(o_target_p1_out), .i_p1_oe(o_target_p1_oe), .i_p2_out(o_target_p2_out),
      .i_p2_oe(o_target_p2_oe), .i_stuck(stuck), .i_ext(ext), .o_p0_level(i_port0_in),
      .o_p3_level(i_sense_port3_high), .o_p3_in(i_input_only_nibble_lines), .o_ds_level(i_sense_strobe_low),
      .o_rw_level(i_sense_rw_low), .o_p1_level(i_target_p1_in), .o_p2_level(i_target_p2_in));
   // The sensing expander sees the same port 0 levels as the input path.
   assign i_sense_port0 = i_port0_in;
   // The clock toggles every half period of 5 ns.
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // ************************************************************
   // Host cycles, comparison and closing.
   // ************************************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic host_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_host_addr <= a;
      i_host_wdata <= d;
      i_host_wr <= 1'b1;
      @(posedge i_clock);
      i_host_wr <= 1'b0;
      #1;
   endtask
   // Reads wait a bounded number of cycles for the valid pulse, then compare the data.
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      int n;
      @(posedge i_clock);
      i_host_addr <= a;
      i_host_rd <= 1'b1;
      @(posedge i_clock);
      i_host_rd <= 1'b0;
      #1;
      n = 0;
      while (o_host_rd_valid !== 1'b1 && n < 4) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      check("rd_valid", {7'h00, o_host_rd_valid}, 8'h01);
      check("rdata", o_host_rdata, exp);
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // The watchdog ends a hung run well after the tests should have finished.
   initial begin
      repeat (3000) @(posedge i_clock);
      err_total++;
      summarize();
   end

   // ************************************************************
   // Test sequence.
   // ************************************************************
   initial begin
      {i_rst_b, i_host_rd, i_host_wr, i_host_addr, i_host_wdata, i_host_bus_out, i_host_bus_oe} = '0;
      {i_host_io1_out, i_host_io1_oe, i_host_xtal, stuck, err_total, compares} = '0;
      {i_host_ds_low, i_host_rw_low, i_host_dm_low, i_host_reset_low} = 4'hF;
      ext = 8'h3C;
      repeat (20) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd_chk(pod_adapter_pkg::ADDR_MODE, pod_adapter_pkg::MODE_RESET);
      host_wr(pod_adapter_pkg::ADDR_MODE, 8'hCB);
      rd_chk(pod_adapter_pkg::ADDR_MODE, 8'hCB);
      host_wr(pod_adapter_pkg::ADDR_MODE, 8'hC0);
      host_wr(pod_adapter_pkg::ADDR_P0_HIGH, 8'h0A);
      host_wr(pod_adapter_pkg::ADDR_P0_LOW, 8'h05);
      // Port 3 is only ever written at its high nibble, never at the input-only address.
      host_wr(pod_adapter_pkg::ADDR_P3_HIGH, 8'h07);
      check("p0_out", o_port0_out, 8'hA5);
      check("p0_oe", o_port0_oe, 8'hFF);
      check("p3_out", {4'h0, o_output_only_nibble_lines}, 8'h07);
      // Line 5 is held low by a fault, so its readback differs from the written value.
      stuck <= 8'h20;
      host_wr(pod_adapter_pkg::ADDR_MODE, 8'hD0);
      rd_chk(pod_adapter_pkg::ADDR_P0_HIGH, 8'h08);
      rd_chk(pod_adapter_pkg::ADDR_P0_LOW, 8'h05);
      rd_chk(pod_adapter_pkg::ADDR_P3_HIGH, 8'h07);
      host_wr(pod_adapter_pkg::ADDR_P0_LOW, 8'h0F);
      check("p0_out", o_port0_out, 8'hA5);
      check("p0_oe", o_port0_oe, 8'hFF);
      rd_chk(pod_adapter_pkg::ADDR_P3_LOW, 8'h03);
      host_wr(pod_adapter_pkg::ADDR_MODE, 8'h10);
      check("ctrl", {6'h00, o_rw_low, o_data_strobe_low}, 8'h00);
      rd_chk(pod_adapter_pkg::ADDR_P3_LOW, 8'h00);
      host_wr(pod_adapter_pkg::ADDR_MODE, 8'h50);
      rd_chk(pod_adapter_pkg::ADDR_P3_LOW, 8'h01);
      // Line 4 follows the data memory select once mode bit 5 is set.
      host_wr(pod_adapter_pkg::ADDR_MODE, 8'hF0);
      @(posedge i_clock);
      i_host_dm_low <= 1'b0;
      #1;
      check("p3_out", {4'h0, o_output_only_nibble_lines}, 8'h06);
      check("dm", {7'h00, o_data_memory_select_low}, 8'h00);
      // Normal reads turn port 0 low nibble into an input; the second read sees the target level.
      host_wr(pod_adapter_pkg::ADDR_MODE, 8'hC0);
      rd_chk(pod_adapter_pkg::ADDR_P0_LOW, 8'h05);
      rd_chk(pod_adapter_pkg::ADDR_P0_LOW, 8'h0C);
      check("p0_oe", o_port0_oe, 8'hF0);
      rd_chk(pod_adapter_pkg::ADDR_P3_LOW, 8'h0C);
      rd_chk(pod_adapter_pkg::ADDR_P3_HIGH, 8'h07);
      rd_chk(16'h2003, 8'h00);
      // The passed ports and wires carry both patterns straight through.
      for (int j = 0; j < 2; j++) begin
         k = (j == 0) ? 8'h5A : 8'hA5;
         @(posedge i_clock);
         {i_host_bus_out, i_host_bus_oe, i_host_io1_out, i_host_io1_oe} <= {k, ~k, ~k, k};
         {i_host_reset_low, i_host_xtal} <= k[1:0];
         #1;
         check("p1_out", o_target_p1_out, k);
         check("p1_oe", o_target_p1_oe, ~k);
         check("p1_in", o_host_bus_in, ext & k);
         check("p2_in", o_host_io1_in, ext & ~k);
         check("p2_out", o_target_p2_out, ~k);
         check("p2_oe", o_target_p2_oe, k);
         check("wires", {6'h00, o_target_reset_low, o_target_xtal}, {6'h00, k[1:0]});
      end
      summarize();
   end
endmodule
